// file: isp_host_model.sv
// host capture model: master clock source and parallel capture
module isp_host_model
  import isp_pkg::*;
(
  input wire logic rst_n,
  output logic master_clk,
  input wire logic pclk,
  input wire logic lv,
  input wire logic [PIX_BITS-1:0] dout,
  output logic [15:0] row_words,
  output logic [15:0] bad_words
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] col_q;
  ////////////////////////////////
  // 19 ns half period keeps us near the nominal rate, inside the range
  initial
  begin
    master_clk = 1'b0;
    forever #19 master_clk = ~master_clk;
  end
  // sample on the pixel clock rising edge, as a grabber latches it
  always @(posedge pclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_q <= CNT_ZERO;
      row_words <= CNT_ZERO;
      bad_words <= CNT_ZERO;
    end
    else if (lv === 1'b1)
    begin
      if (dout !== col_q[PIX_BITS-1:0])
        bad_words <= bad_words + CNT_ONE;
      col_q <= col_q + CNT_ONE;
    end
    else if (col_q != CNT_ZERO)
    begin
      row_words <= col_q; // a z on lv also ends the row
      col_q <= CNT_ZERO;
    end
  end
endmodule : isp_host_model

// file: isp_pin_top.sv
// image sensor pin interface: readout sequencer, pin timing, sync pins
// How it works
// - in snapshot or slave mode a trigger rising edge starts exposure
// - active-low reset clears all state at once, without a clock, except the stereo buffer storage
// - parallel outputs are driven only while output enable is high
// - output enable low floats data, line valid, frame valid, pixel clock
// - line sync drives a start-of-line pulse as master, accepts it as slave
// - frame sync drives a start-of-frame pulse as master, accepts it as slave
// - line valid is high only while data is valid; frame valid also spans the gaps between rows
// - data is stable at the pixel clock rising edge
// - the error output follows the stereo error flag
// - standby halts sensor operation
// - two select pins choose the two-wire bus address
// - stereo mode takes serial data and shift clock from the partner
// - one pixel word per pixel clock period while line valid
// - pixel clock is the inverted master clock
// - pixel clock toggles continuously outside standby, blanking included
module isp_pin_top
  import isp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_clk,
  input wire logic exposure,
  input wire logic standby,
  input wire logic out_en,
  input wire logic mode_snapshot,
  input wire logic mode_slave,
  input wire logic stereo_en,
  input wire logic bus_id_sel0,
  input wire logic bus_id_sel1,
  input wire logic line_sync_i,
  output logic line_sync_o,
  output logic line_sync_oe,
  input wire logic frame_sync_i,
  output logic frame_sync_o,
  output logic frame_sync_oe,
  input wire logic stereo_rx_clk_p,
  input wire logic stereo_rx_p,
  input wire logic stereo_rx_n,
  output logic [PIX_BITS-1:0] pix_data,
  output logic line_valid,
  output logic frame_valid,
  output logic pixel_strobe_clk,
  output logic pix_oe,
  output logic stereo_error,
  output logic illum_strobe,
  output logic [6:0] bus_id
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; s3 exists only for edge detection
  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;

  assign pin_raw = {stereo_en, mode_slave, mode_snapshot, bus_id_sel1,
                    bus_id_sel0, out_en, standby, frame_sync_i, line_sync_i,
                    exposure, master_clk};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // rising edges and levels of the synchronised pins
  logic stby;
  logic snap;
  logic slave;
  logic pix_tick;
  logic exp_rise;
  logic lsync_rise;
  logic fsync_rise;
  logic [PIN_N-1:0] rise;

  assign rise = s2_q & ~s3_q;
  assign stby = s2_q[PIN_STBY];
  assign snap = s2_q[PIN_SNAP];
  assign slave = s2_q[PIN_SLAVE];
  // sequencer only advances on master clock rising edges
  assign pix_tick = rise[PIN_MCLK] && !stby;
  assign exp_rise = rise[PIN_EXP] && (snap || slave);
  assign lsync_rise = rise[PIN_LSYNC] && slave;
  assign fsync_rise = rise[PIN_FSYNC] && slave;

  ////////////////////////////////////////////////////////////////////////////
  // stereo receiver
  isp_stereo_if st_if ();

  isp_stereo_rx u_stereo (
    .clk(clk),
    .rst_n(rst_n),
    .stereo_rx_clk_p(stereo_rx_clk_p),
    .stereo_rx_p(stereo_rx_p),
    .stereo_rx_n(stereo_rx_n),
    .st(st_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // readout sequencer
  isp_state_e state_q;
  isp_state_e state_d;
  logic [15:0] cnt_q;
  logic [15:0] row_q;
  logic [15:0] len;
  logic cnt_done;
  logic last_row;
  logic exp_pend_q;
  logic fs_pend_q;
  logic ls_pend_q;
  logic take_exp;
  logic take_fs;
  logic take_ls;
  logic advance;

  // data is valid only in active rows
  function automatic logic data_state(isp_state_e s);
    data_state = (s == ST_ACTIVE);
  endfunction : data_state

  // frame valid spans the rows, including the gaps between them
  function automatic logic frame_state(isp_state_e s);
    frame_state = (s == ST_ACTIVE) || (s == ST_HBLANK);
  endfunction : frame_state

  // length of each timed state, in pixel periods
  always_comb
  begin
    case (state_q)
      ST_EXPOSE: len = EXPOSE_PIX;
      ST_FSTART: len = FSTART_PIX;
      ST_ACTIVE: len = ACT_COLS;
      ST_HBLANK: len = HBLANK_PIX;
      ST_FEND: len = FEND_PIX;
      ST_VBLANK: len = VBLANK_PIX;
      default: len = CNT_ONE;
    endcase
  end

  assign cnt_done = (cnt_q == len - CNT_ONE);
  assign last_row = (row_q == ACT_ROWS - CNT_ONE);

  // next state; waits for slave sync pulses where the partner leads
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (!snap && !slave)
          state_d = ST_FSTART;
        else if (exp_pend_q)
          state_d = ST_EXPOSE;
      end
      ST_EXPOSE:
        if (cnt_done)
          state_d = slave ? ST_WAIT_FRM : ST_FSTART;
      ST_WAIT_FRM:
        if (fs_pend_q)
          state_d = ST_FSTART;
      ST_FSTART:
        if (cnt_done)
          state_d = ST_ACTIVE;
      ST_ACTIVE:
        if (cnt_done)
          state_d = last_row ? ST_FEND : ST_HBLANK;
      ST_HBLANK:
        if (cnt_done && (!slave || ls_pend_q))
          state_d = ST_ACTIVE;
      ST_FEND:
        if (cnt_done)
          state_d = ST_VBLANK;
      ST_VBLANK:
        if (cnt_done)
          state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  assign advance = pix_tick && (state_d != state_q);
  assign take_exp = pix_tick && (state_q == ST_IDLE);
  assign take_fs = pix_tick && (state_q == ST_WAIT_FRM);
  assign take_ls = advance && (state_q == ST_HBLANK);

  // state, position counters; standby parks the sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      row_q <= CNT_ZERO;
    end
    else if (stby)
    begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ZERO;
      row_q <= CNT_ZERO;
    end
    else if (pix_tick)
    begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? CNT_ZERO :
               (cnt_done ? cnt_q : cnt_q + CNT_ONE);
      if (state_q == ST_FSTART)
        row_q <= CNT_ZERO;
      else if (take_ls)
        row_q <= row_q + CNT_ONE;
    end
  end

  // pending trigger and sync events; a new edge beats the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      exp_pend_q <= 1'b0;
      fs_pend_q <= 1'b0;
      ls_pend_q <= 1'b0;
    end
    else
    begin
      exp_pend_q <= exp_rise || (exp_pend_q && !take_exp);
      fs_pend_q <= fsync_rise || (fs_pend_q && !take_fs);
      ls_pend_q <= lsync_rise || (ls_pend_q && !take_ls);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel outputs, updated on master rising edge, pixel clock low then
  logic stereo_sel;
  logic [PIX_BITS-1:0] pix_next;
  logic [15:0] col_next;
  logic going_active;

  assign going_active = pix_tick && data_state(state_d);
  // column of the word being launched: zero on the first pixel of a row
  assign col_next = (state_d != state_q) ? CNT_ZERO : cnt_q + CNT_ONE;
  assign stereo_sel = s2_q[PIN_STEREO] && st_if.valid;
  // stereo words take the pixel slot; else a column ramp is shown
  assign pix_next = stereo_sel ? st_if.word : col_next[PIX_BITS-1:0];
  // outside stereo mode stale words are drained so the link never stalls
  assign st_if.ready = !s2_q[PIN_STEREO] || going_active;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pix_data <= '0;
      line_valid <= 1'b0;
      frame_valid <= 1'b0;
    end
    else if (stby)
    begin
      pix_data <= '0;
      line_valid <= 1'b0;
      frame_valid <= 1'b0;
    end
    else if (pix_tick)
    begin
      pix_data <= going_active ? pix_next : '0;
      line_valid <= data_state(state_d);
      frame_valid <= frame_state(state_d) &&
                     !(state_d == ST_HBLANK && last_row);
    end
  end

  // inverted master clock; edges of data fall mid period
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pixel_strobe_clk <= 1'b0;
    else
      pixel_strobe_clk <= !s2_q[PIN_MCLK] && !stby;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync pins, enables, misc outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_sync_o <= 1'b0;
      frame_sync_o <= 1'b0;
      line_sync_oe <= 1'b0;
      frame_sync_oe <= 1'b0;
      pix_oe <= 1'b0;
      stereo_error <= 1'b0;
      illum_strobe <= 1'b0;
      bus_id <= 7'h00;
    end
    else
    begin
      // pulse lasts one pixel period: line sync with the row's first word, frame sync 71 periods ahead of row 0
      if (pix_tick)
      begin
        line_sync_o <= !slave && advance && data_state(state_d);
        frame_sync_o <= !slave && advance && (state_d == ST_FSTART);
      end
      line_sync_oe <= !slave;
      frame_sync_oe <= !slave;
      pix_oe <= s2_q[PIN_OE];
      stereo_error <= st_if.err;
      illum_strobe <= (state_q == ST_EXPOSE);
      bus_id <= {BUS_ID_BASE, s2_q[PIN_SEL1], s2_q[PIN_SEL0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [5:0] stall_q;
  // cycles since the pixel clock last moved
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stall_q <= 6'h00;
    else if (stby || $changed(pixel_strobe_clk))
      stall_q <= 6'h00;
    else if (stall_q != PCLK_STALL_MAX)
      stall_q <= stall_q + 6'h01;
  end

  chk_trigger_starts: assert property (
    (state_q == ST_IDLE) && exp_rise && !stby ##1 !stby [*2]
      |-> ##[0:40] state_q == ST_EXPOSE)
    else $error("trigger edge did not start exposure");

  chk_oe_floats: assert property (
    !s2_q[PIN_OE] |=> !pix_oe)
    else $error("outputs driven with enable low");

  chk_oe_drives: assert property (
    $rose(s2_q[PIN_OE]) |=> pix_oe)
    else $error("enable high but outputs not driven");

  chk_lv_in_frame: assert property (
    line_valid |-> frame_valid)
    else $error("line valid outside frame valid");

  chk_data_at_edge: assert property (
    $changed(pix_data) |-> !pixel_strobe_clk)
    else $error("pixel data moved while pixel clock high");

  chk_one_per_tick: assert property (
    line_valid && $changed(pix_data) |-> $past(pix_tick))
    else $error("pixel word changed without a pixel period");

  chk_error_follows: assert property (
    st_if.err |=> stereo_error)
    else $error("error pin does not follow stereo flag");

  chk_standby_halts: assert property (
    stby |=> (state_q == ST_IDLE) && !line_valid && !frame_valid)
    else $error("sequencer running in standby");

  chk_bus_select: assert property (
    $stable(s2_q[PIN_SEL1:PIN_SEL0]) [*2]
      |-> bus_id[1:0] == s2_q[PIN_SEL1:PIN_SEL0])
    else $error("bus address ignores select pins");

  chk_lsync_master: assert property (
    !slave && pix_tick && advance && (state_d == ST_ACTIVE)
      |=> line_sync_o && line_sync_oe)
    else $error("no start-of-line pulse as master");

  chk_fsync_slave: assert property (
    slave |=> !frame_sync_oe && !line_sync_oe)
    else $error("sync pins driven in slave mode");

  chk_pclk_toggles: assert property (
    !stby |-> stall_q != PCLK_STALL_MAX)
    else $error("pixel clock stopped");

endmodule : isp_pin_top

// file: isp_pin_top_tb_top.sv
// self-checking bench for the image sensor pin interface
module isp_pin_top_tb_top;
  import isp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic exposure = 1'b0;
  logic standby = 1'b0;
  logic out_en = 1'b1;
  logic mode_snap = 1'b1;
  logic mode_slv = 1'b0;
  logic fs_drv = 1'b0;
  logic sel0 = 1'b0;
  logic sel1 = 1'b1;
  logic lclk = 1'b0;
  logic srx_p = 1'b0;
  logic srx_n = 1'b1;
  logic [PIX_BITS-1:0] pix_data;
  logic line_valid, frame_valid, pclk_o, pix_oe, stereo_error;
  logic illum_strobe, ls_o, ls_oe, fs_o, fs_oe, saw_ls, saw_fs;
  logic [6:0] bus_id;
  logic [15:0] row_words, bad_words;
  wire mclk;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  int pedges = 0;
  // pins as the board sees them; slave side pulls line sync low and drives frame sync from fs_drv
  wire [PIX_BITS-1:0] dout_pin = pix_oe ? pix_data : 'z;
  wire lv_pin = pix_oe ? line_valid : 1'bz;
  wire fv_pin = pix_oe ? frame_valid : 1'bz;
  wire pclk_pin = pix_oe ? pclk_o : 1'bz;
  wire ls_pin = ls_oe ? ls_o : 1'b0;
  wire fs_pin = fs_oe ? fs_o : fs_drv;
  ////////////////////////////////
  isp_pin_top isp_pin_top_inst (.clk(clk), .rst_n(rst_n),
    .master_clk(mclk), .exposure(exposure), .standby(standby),
    .out_en(out_en), .mode_snapshot(mode_snap), .mode_slave(mode_slv),
    .stereo_en(1'b0), .bus_id_sel0(sel0), .bus_id_sel1(sel1),
    .line_sync_i(ls_pin), .line_sync_o(ls_o), .line_sync_oe(ls_oe),
    .frame_sync_i(fs_pin), .frame_sync_o(fs_o), .frame_sync_oe(fs_oe),
    .stereo_rx_clk_p(lclk), .stereo_rx_p(srx_p), .stereo_rx_n(srx_n),
    .pix_data(pix_data), .line_valid(line_valid),
    .frame_valid(frame_valid), .pixel_strobe_clk(pclk_o),
    .pix_oe(pix_oe), .stereo_error(stereo_error),
    .illum_strobe(illum_strobe), .bus_id(bus_id));
  isp_host_model isp_host_model_inst (.rst_n(rst_n), .master_clk(mclk),
    .pclk(pclk_pin), .lv(lv_pin), .dout(dout_pin),
    .row_words(row_words), .bad_words(bad_words));
  ////////////////////////////////
  // clock, sticky sync monitors, edge count and hang guard
  always #2 clk = ~clk;
  always @(posedge pclk_o) pedges++;
  always @(posedge clk)
  begin
    saw_ls <= (cyc == 0) ? 1'b0 : (saw_ls | (ls_o === 1'b1));
    saw_fs <= (cyc == 0) ? 1'b0 : (saw_fs | (fs_o === 1'b1));
    cyc++;
    if (cyc == 60000)
    begin
      err_total++;
      $display("ERROR timeout expected done seen hang");
      final_report;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic wait_lv(input logic v, input int lim);
    for (int k = 0; k < lim && lv_pin !== v; k++) @(posedge clk);
  endtask : wait_lv
  // link clock runs only while a word is on the wire
  task automatic send_word(input logic [PIX_BITS-1:0] w, input logic bad);
    for (int i = PIX_BITS - 1; i >= 0; i--)
    begin
      srx_p = w[i];
      srx_n = bad ? w[i] : ~w[i];
      #6 lclk = 1'b1;
      #6 lclk = 1'b0;
    end
    srx_p = 1'b0;
    srx_n = 1'b1;
  endtask : send_word
  ////////////////////////////////
  task automatic t_idle;
    chk("bus_id", {BUS_ID_BASE, 2'b10}, bus_id);
    chk("line_sync_oe", 1'b1, ls_oe);
    chk("frame_sync_oe", 1'b1, fs_oe);
    repeat (1500) @(posedge clk);
    chk("lv untriggered", 1'b0, lv_pin);
    chk("illum untriggered", 1'b0, illum_strobe);
    $display("test idle done");
  endtask : t_idle
  task automatic t_snap;
    int k;
    exposure <= 1'b1;
    for (k = 0; k < 60 && illum_strobe !== 1'b1; k++) @(posedge clk);
    chk("illum_strobe", 1'b1, illum_strobe);
    exposure <= 1'b0;
    wait_lv(1'b1, 20000);
    chk("lv rise", 1'b1, lv_pin);
    chk("fv in row", 1'b1, fv_pin);
    wait_lv(1'b0, 9000);
    repeat (30) @(posedge clk);
    chk("row words", ACT_COLS, row_words);
    chk("bad words", CNT_ZERO, bad_words);
    chk("line sync pulse", 1'b1, saw_ls);
    chk("frame sync pulse", 1'b1, saw_fs);
    $display("test snapshot done");
  endtask : t_snap
  task automatic t_blank;
    pedges = 0;
    repeat (200) @(posedge clk);
    chk("pclk blank edges", 1'b1, pedges >= 19 && pedges <= 23);
    chk("lv in blank", 1'b0, lv_pin);
    $display("test blanking done");
  endtask : t_blank
  task automatic t_oe;
    out_en <= 1'b0;
    repeat (10) @(posedge clk);
    chk("pix_oe low", 1'b0, pix_oe);
    chk("lv float", 1'bz, lv_pin);
    chk("fv float", 1'bz, fv_pin);
    chk("data float", 10'bz, dout_pin);
    chk("pclk float", 1'bz, pclk_pin);
    out_en <= 1'b1;
    repeat (10) @(posedge clk);
    chk("pix_oe high", 1'b1, pix_oe);
    $display("test output enable done");
  endtask : t_oe
  task automatic t_stby;
    standby <= 1'b1;
    repeat (20) @(posedge clk);
    pedges = 0;
    repeat (200) @(posedge clk);
    chk("standby edges", 0, pedges);
    chk("standby pclk", 1'b0, pclk_o);
    standby <= 1'b0;
    repeat (40) @(posedge clk);
    pedges = 0;
    repeat (100) @(posedge clk);
    chk("resume edges", 1'b1, pedges != 0);
    $display("test standby done");
  endtask : t_stby
  task automatic t_stereo;
    send_word(10'h2A5, 1'b0);
    send_word(10'h1C3, 1'b0);
    repeat (20) @(posedge clk);
    chk("stereo clean", 1'b0, stereo_error);
    send_word(10'h3FF, 1'b1);
    repeat (20) @(posedge clk);
    chk("stereo error", 1'b1, stereo_error);
    $display("test stereo done");
  endtask : t_stereo
  task automatic t_reset;
    mode_snap <= 1'b0;
    sel0 <= 1'b1;
    sel1 <= 1'b0;
    wait_lv(1'b1, 10000);
    #1 rst_n = 1'b0;
    #1 chk("lv in reset", 1'b0, line_valid);
    chk("data in reset", 10'h000, pix_data);
    chk("oe in reset", 1'b0, pix_oe);
    chk("error in reset", 1'b0, stereo_error);
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("bus_id", {BUS_ID_BASE, 2'b01}, bus_id);
    wait_lv(1'b1, 2000);
    chk("free run row", 1'b1, lv_pin);
    $display("test reset done");
  endtask : t_reset
  // slave: sync pins released, frame waits for the partner's frame sync
  task automatic t_slave;
    int k;
    mode_slv <= 1'b1;
    repeat (10) @(posedge clk);
    chk("slave ls_oe", 1'b0, ls_oe);
    chk("slave fs_oe", 1'b0, fs_oe);
    exposure <= 1'b1;
    for (k = 0; k < 60 && illum_strobe !== 1'b1; k++) @(posedge clk);
    chk("slave illum", 1'b1, illum_strobe);
    exposure <= 1'b0;
    for (k = 0; k < 9000 && illum_strobe !== 1'b0; k++) @(posedge clk);
    repeat (100) @(posedge clk);
    chk("slave waits sync", 1'b0, fv_pin);
    fs_drv <= 1'b1;
    repeat (20) @(posedge clk);
    fs_drv <= 1'b0;
    wait_lv(1'b1, 2000);
    chk("slave frame start", 1'b1, lv_pin);
    mode_slv <= 1'b0;
    $display("test slave done");
  endtask : t_slave
  task final_report;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    t_idle;
    t_snap;
    t_blank;
    t_oe;
    t_stby;
    t_stereo;
    t_slave;
    t_reset;
    final_report;
  end
endmodule : isp_pin_top_tb_top

// file: isp_pkg.sv
// shared constants and types for the image sensor pin interface
package isp_pkg;

  // pixel word width on the parallel port and on the stereo link
  localparam int PIX_BITS = 10;

  // frame geometry, counted in pixel clock periods
  localparam logic [15:0] ACT_COLS = 16'h02F0;     // 752 active pixels
  localparam logic [15:0] HBLANK_PIX = 16'h005E;   // 94 pixels of blanking
  localparam logic [15:0] FSTART_PIX = 16'h0047;   // 71 pixels before row 0
  localparam logic [15:0] FEND_PIX = 16'h0017;     // 23 pixels after last row
  localparam logic [15:0] VBLANK_PIX = 16'h94BA;   // 38074 pixels
  localparam logic [15:0] ACT_ROWS = 16'h01E0;     // 480 rows
  localparam logic [15:0] EXPOSE_PIX = 16'h034E;   // default exposure length
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // two-wire bus address: upper bits fixed, value arbitrary
  localparam logic [4:0] BUS_ID_BASE = 5'h12;

  // stereo buffer shape
  localparam int BUF_DEPTH = 2;
  localparam int BUF_AW = 1;

  // slowest allowed master clock half period, in core clock cycles
  localparam logic [5:0] PCLK_STALL_MAX = 6'h28;

  // positions inside the synchronised pin vector
  localparam int PIN_MCLK = 0;
  localparam int PIN_EXP = 1;
  localparam int PIN_LSYNC = 2;
  localparam int PIN_FSYNC = 3;
  localparam int PIN_STBY = 4;
  localparam int PIN_OE = 5;
  localparam int PIN_SEL0 = 6;
  localparam int PIN_SEL1 = 7;
  localparam int PIN_SNAP = 8;
  localparam int PIN_SLAVE = 9;
  localparam int PIN_STEREO = 10;
  localparam int PIN_N = 11;

  // readout sequencer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EXPOSE = 3'h1,
    ST_WAIT_FRM = 3'h2,
    ST_FSTART = 3'h3,
    ST_ACTIVE = 3'h4,
    ST_HBLANK = 3'h5,
    ST_FEND = 3'h6,
    ST_VBLANK = 3'h7
  } isp_state_e;

endpackage : isp_pkg

// file: isp_stereo_if.sv
// carrier between the stereo receiver and the readout engine
interface isp_stereo_if;
  import isp_pkg::*;
  logic [PIX_BITS-1:0] word;
  logic valid;
  logic ready;
  logic err;
  modport src (output word, output valid, output err, input ready);
  modport snk (input word, input valid, input err, output ready);
endinterface : isp_stereo_if

// file: isp_stereo_rx.sv
// stereo serial receiver: link-clock shifter, toggle crossing, 2-entry buffer
module isp_stereo_rx
  import isp_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stereo_rx_clk_p,
  input wire logic stereo_rx_p,
  input wire logic stereo_rx_n,
  isp_stereo_if.src st
);

  ////////////////////////////////////////////////////////////////////////////
  // link domain
  logic [PIX_BITS-1:0] sh_q;
  logic [PIX_BITS-1:0] hold_q;
  logic [3:0] bit_q;
  logic req_q;
  logic ack_l1_q;
  logic ack_l2_q;
  logic err_l_q;
  // driven in the core domain below, read here only by the first ack stage
  logic ack_q;
  logic word_done;
  logic busy;
  logic [PIX_BITS-1:0] word_in;

  assign word_done = (bit_q == 4'(PIX_BITS - 1));
  // busy until the core has acknowledged the previous word
  assign busy = (req_q != ack_l2_q);
  assign word_in = {sh_q[PIX_BITS-2:0], stereo_rx_p};

  // shift msb first; hold_q only changes while no request is outstanding
  always_ff @(posedge stereo_rx_clk_p or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_q <= '0;
      hold_q <= '0;
      bit_q <= 4'h0;
      req_q <= 1'b0;
      err_l_q <= 1'b0;
    end
    else
    begin
      sh_q <= word_in;
      bit_q <= word_done ? 4'h0 : bit_q + 4'h1;
      if (word_done && !busy)
      begin
        hold_q <= word_in;
        req_q <= ~req_q;
      end
      // overrun or a non-complementary pair is a stereo error
      if ((word_done && busy) || (stereo_rx_p == stereo_rx_n))
        err_l_q <= 1'b1;
    end
  end

  // ack toggle back into the link domain
  always_ff @(posedge stereo_rx_clk_p or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_l1_q <= 1'b0;
      ack_l2_q <= 1'b0;
    end
    else
    begin
      ack_l1_q <= ack_q;
      ack_l2_q <= ack_l1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // core domain
  logic req_s1_q;
  logic req_s2_q;
  logic err_s1_q;
  logic err_s2_q;
  logic [PIX_BITS-1:0] mem_q [BUF_DEPTH];
  logic [BUF_AW-1:0] wr_q;
  logic [BUF_AW-1:0] rd_q;
  logic [BUF_AW:0] cnt_q;
  logic full;
  logic push;
  logic pop;

  // a full buffer holds off the ack, which stalls the link side
  assign full = (cnt_q == (BUF_AW+1)'(BUF_DEPTH));
  assign push = (req_s2_q != ack_q) && !full;
  assign pop = st.valid && st.ready;
  assign st.valid = (cnt_q != '0);
  assign st.word = mem_q[rd_q];
  assign st.err = err_s2_q;

  // synchronisers for the request toggle and the error level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      err_s1_q <= 1'b0;
      err_s2_q <= 1'b0;
    end
    else
    begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      err_s1_q <= err_l_q;
      err_s2_q <= err_s1_q;
    end
  end

  // buffer pointers and fill count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        ack_q <= req_s2_q;
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (BUF_AW+1)'(push) - (BUF_AW+1)'(pop);
    end
  end

  // storage needs no reset; valid guards every read
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= hold_q;
  end

endmodule : isp_stereo_rx
